// [ext_bus_map.vh]
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH
// Size output codes {xfer_len_hi, xfer_len_lo}
`define LEN_BYTE      2'b01
`define LEN_WORD      2'b10
`define LEN_THREE     2'b11
`define LEN_LONG      2'b00
// Request size codes
`define REQ_BYTE      2'b00
`define REQ_WORD      2'b01
`define REQ_LONG      2'b10
// Byte counts
`define CNT_ONE       3'h1
`define CNT_TWO       3'h2
`define CNT_FOUR      3'h4
// Bus cycle states
`define ST_IDLE       3'h0
`define ST_ADDR       3'h1
`define ST_DATA       3'h2
`define ST_WAIT       3'h3
`define ST_DONE       3'h4
// Internal acknowledge wait-state counter width
`define WAIT_W        4
`define WAIT_ZERO     4'h0
`define WAIT_ONE      4'h1
`endif

// [int_ack_gen.v]
`timescale 1ns/1ps
`include "ext_bus_map.vh"
// Internal acknowledge generator, instanced once inside ext_bus_sizer
module int_ack_gen (
    // Clock and reset
    input  wire               ref_clk,
    input  wire               rst_n,
    input  wire               clk_en,
    // Control
    input  wire               start,
    input  wire               cycle_end,
    input  wire               use_int,
    input  wire [`WAIT_W-1:0] wait_states,
    input  wire               port_16,
    // Acknowledge out, active low like the pins
    output reg                ack_hi_n,
    output reg                ack_lo_n
);
    reg [`WAIT_W-1:0] count;
    reg               busy;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count    <= `WAIT_ZERO;
            busy     <= 1'b0;
            ack_hi_n <= 1'b1;
            ack_lo_n <= 1'b1;
        end else if (clk_en) begin
            if (cycle_end) begin
                busy     <= 1'b0;
                ack_hi_n <= 1'b1;
                ack_lo_n <= 1'b1;
            end else if (start && use_int) begin
                busy  <= 1'b1;
                count <= wait_states;
            end else if (busy) begin
                if (count == `WAIT_ZERO) begin
                    // Port width encoded as on the external lines
                    ack_hi_n <= ~port_16;
                    ack_lo_n <= port_16;
                end else begin
                    count <= count - `WAIT_ONE;
                end
            end
        end
    end
endmodule

// [ext_bus_sizer.v]
`timescale 1ns/1ps
`include "ext_bus_map.vh"
module ext_bus_sizer (
    // Clock and reset
    input  wire               ref_clk,
    input  wire               rst_n,
    input  wire               clk_en,
    // Operand request from the core side
    input  wire               req_valid,
    input  wire               req_write,
    input  wire [1:0]         req_size,
    input  wire [23:0]        req_addr,
    input  wire [31:0]        req_wdata,
    input  wire               req_int_ack,
    input  wire [`WAIT_W-1:0] req_wait,
    input  wire               req_int_16,
    output reg                req_ready,
    output reg                done,
    output reg                misaligned,
    output reg  [31:0]        rdata,
    // External bus
    output reg  [23:0]        addr,
    output reg                xfer_len_hi,
    output reg                xfer_len_lo,
    output reg                rw,
    output reg                addr_strobe_n,
    output reg                data_strobe_n,
    output reg  [15:0]        data_out,
    output reg                data_oe_n,
    input  wire [15:0]        data_in,
    input  wire               port_ack_lo,
    input  wire               port_ack_hi
);
    reg  [2:0]  state;
    reg  [2:0]  remain;
    reg  [31:0] opnd;
    reg         use_int;
    reg         start_pulse;
    reg  [15:0] data_s1;
    reg  [15:0] data_s2;
    reg  [1:0]  ack_s1;
    reg  [1:0]  ack_s2;
    wire        int_hi_n;
    wire        int_lo_n;
    wire        ack_hi;
    wire        ack_lo;
    wire        end8;
    wire        end16;
    wire [2:0]  moved;
    wire [7:0]  cur_byte;
    wire [2:0]  next_remain;

    // Size code for a count of remaining bytes
    function [1:0] len_code;
        input [2:0] n;
        begin
            case (n)
                `CNT_ONE: len_code = `LEN_BYTE;
                `CNT_TWO: len_code = `LEN_WORD;
                `CNT_FOUR: len_code = `LEN_LONG;
                default: len_code = `LEN_THREE;
            endcase
        end
    endfunction

    // Operand byte at the head of what remains
    function [7:0] head_byte;
        input [31:0] v;
        input [2:0]  n;
        begin
            case (n)
                `CNT_FOUR: head_byte = v[31:24];
                3'h3: head_byte = v[23:16];
                `CNT_TWO: head_byte = v[15:8];
                default: head_byte = v[7:0];
            endcase
        end
    endfunction

    int_ack_gen u_ack (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .clk_en      (clk_en),
        .start       (start_pulse),
        .cycle_end   (state == `ST_DONE),
        .use_int     (use_int),
        .wait_states (req_wait),
        .port_16     (req_int_16),
        .ack_hi_n    (int_hi_n),
        .ack_lo_n    (int_lo_n)
    );

    // Pins are asynchronous: two flops before any use
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_s1 <= 16'h0000;
            data_s2 <= 16'h0000;
            ack_s1  <= 2'h3;
            ack_s2  <= 2'h3;
        end else if (clk_en) begin
            data_s1 <= data_in;
            data_s2 <= data_s1;
            ack_s1  <= {port_ack_hi, port_ack_lo};
            ack_s2  <= ack_s1;
        end
    end

    assign ack_hi = use_int ? int_hi_n : ack_s2[1];
    assign ack_lo = use_int ? int_lo_n : ack_s2[0];
    assign end8   = ack_hi & ~ack_lo;
    assign end16  = ~ack_hi & ack_lo;
    // A 16-bit port takes two bytes only when aligned and at least two remain
    assign moved  = (end16 && !addr[0] && remain >= `CNT_TWO) ?
                    `CNT_TWO : `CNT_ONE;
    assign next_remain = remain - moved;
    assign cur_byte    = head_byte(opnd, remain);

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= `ST_IDLE;
            remain        <= 3'h0;
            opnd          <= 32'h00000000;
            use_int       <= 1'b0;
            start_pulse   <= 1'b0;
            req_ready     <= 1'b0;
            done          <= 1'b0;
            misaligned    <= 1'b0;
            rdata         <= 32'h00000000;
            addr          <= 24'h000000;
            xfer_len_hi   <= 1'b0;
            xfer_len_lo   <= 1'b1;
            rw            <= 1'b1;
            addr_strobe_n <= 1'b1;
            data_strobe_n <= 1'b1;
            data_out      <= 16'h0000;
            data_oe_n     <= 1'b1;
        end else if (clk_en) begin
            start_pulse <= 1'b0;
            done        <= 1'b0;
            misaligned  <= 1'b0;
            req_ready   <= (state == `ST_IDLE) && !req_valid;
            case (state)
                `ST_IDLE: begin
                    // A request still standing in the done cycle is old
                    if (req_valid && !done) begin
                        if (req_size != `REQ_BYTE && req_addr[0]) begin
                            misaligned <= 1'b1;
                            done       <= 1'b1;
                        end else begin
                            // Assume the widest port first
                            remain <= (req_size == `REQ_LONG) ? `CNT_FOUR :
                                      (req_size == `REQ_WORD) ? `CNT_TWO :
                                      `CNT_ONE;
                            opnd   <= req_wdata;
                            addr   <= req_addr;
                            rw     <= ~req_write;
                            use_int <= req_int_ack;
                            rdata  <= 32'h00000000;
                            state  <= `ST_ADDR;
                        end
                    end
                end
                `ST_ADDR: begin
                    {xfer_len_hi, xfer_len_lo} <= len_code(remain);
                    addr_strobe_n <= 1'b0;
                    start_pulse   <= 1'b1;
                    if (rw) begin
                        data_strobe_n <= 1'b0;
                        state <= `ST_WAIT;
                    end else begin
                        data_oe_n <= 1'b0;
                        // All 16 lines driven; a single byte is copied onto both lanes
                        if (remain >= `CNT_TWO && !addr[0])
                            data_out <= {cur_byte,
                                head_byte(opnd, remain - 3'h1)};
                        else
                            data_out <= {cur_byte, cur_byte};
                        state <= `ST_DATA;
                    end
                end
                `ST_DATA: begin
                    data_strobe_n <= 1'b0;
                    state <= `ST_WAIT;
                end
                `ST_WAIT: begin
                    if (end8 || end16) begin
                        if (rw) begin
                            // Only the designated lane is latched, or both lanes when two bytes move
                            if (end16 && !addr[0] && moved == `CNT_TWO)
                                rdata <= {rdata[15:0], data_s2};
                            else if (end16 && addr[0])
                                rdata <= {rdata[23:0], data_s2[7:0]};
                            else
                                rdata <= {rdata[23:0], data_s2[15:8]};
                        end
                        addr_strobe_n <= 1'b1;
                        data_strobe_n <= 1'b1;
                        data_oe_n     <= 1'b1;
                        remain <= next_remain;
                        addr   <= addr + {21'h000000, moved};
                        state  <= `ST_DONE;
                    end
                end
                `ST_DONE: begin
                    // Wait for the synced acknowledge to fall back, else
                    // the next cycle would end on the stale one
                    if (!(end8 || end16)) begin
                        if (remain == 3'h0) begin
                            done  <= 1'b1;
                            state <= `ST_IDLE;
                        end else begin
                            state <= `ST_ADDR;
                        end
                    end
                end
                default: state <= `ST_IDLE;
            endcase
        end
    end
endmodule

// [ext_bus_sizer_properties.sv]
`timescale 1ns/1ps
module ext_bus_sizer_properties (
    // Clock, reset and request
    input wire        ref_clk,
    input wire        rst_n,
    input wire [1:0]  req_size,
    input wire [31:0] req_wdata,
    input wire        done,
    input wire        misaligned,
    // External bus
    input wire [23:0] addr,
    input wire        xfer_len_hi,
    input wire        xfer_len_lo,
    input wire        rw,
    input wire        addr_strobe_n,
    input wire        data_strobe_n,
    input wire [15:0] data_out,
    input wire        data_oe_n,
    input wire        port_ack_lo,
    input wire        port_ack_hi
);
    wire [1:0] len = {xfer_len_hi, xfer_len_lo};
    wire       wr = !data_strobe_n && !rw;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_hold;
        !addr_strobe_n && $past(!addr_strobe_n) |-> $stable({addr, len, rw});
    endproperty
    property p_mis;
        misaligned |-> done && addr_strobe_n && $past(addr_strobe_n);
    endproperty
    property p_long_even;
        !addr_strobe_n && len == 2'b00 |-> !addr[0];
    endproperty
    property p_three;
        !addr_strobe_n && len == 2'b11 |-> addr[0] && req_size == 2'b10;
    endproperty
    property p_word;
        !addr_strobe_n && req_size == 2'b01 |->
            (len == 2'b10 && !addr[0]) || (len == 2'b01 && addr[0]);
    endproperty
    property p_lower_word;
        wr && len == 2'b10 |-> data_out == req_wdata[15:0];
    endproperty
    property p_upper_word;
        wr && len == 2'b00 |-> data_out == req_wdata[31:16];
    endproperty
    property p_byte_lane;
        wr && req_size == 2'b00 |->
            (addr[0] ? data_out[7:0] : data_out[15:8]) == req_wdata[7:0];
    endproperty
    property p_ack_end;
        $rose(port_ack_lo ^ port_ack_hi) |-> ##[1:8] addr_strobe_n;
    endproperty
    property p_drive;
        (!data_oe_n) == (!rw && !addr_strobe_n);
    endproperty
    a_hold: assert property (p_hold)
        else $error("cycle fields moved");
    a_mis: assert property (p_mis)
        else $error("refusal ran a cycle");
    a_long_even: assert property (p_long_even)
        else $error("odd long");
    a_three: assert property (p_three)
        else $error("bad three");
    a_word: assert property (p_word)
        else $error("bad word cycle");
    a_lower_word: assert property (p_lower_word)
        else $error("word lane");
    a_upper_word: assert property (p_upper_word)
        else $error("upper word");
    a_byte_lane: assert property (p_byte_lane)
        else $error("byte lane");
    a_ack_end: assert property (p_ack_end)
        else $error("ack ignored");
    a_drive: assert property (p_drive)
        else $error("data drive outside write cycle");
    c_mis: cover property (misaligned);
    c_three: cover property (!addr_strobe_n && len == 2'b11);
    c_ack8: cover property ($rose(port_ack_lo ^ port_ack_hi) && port_ack_hi);
endmodule

// [ext_slave_model.sv]
`timescale 1ns/1ps
module ext_slave_model (
    // Bus from the master
    input  wire        ref_clk,
    input  wire [23:0] addr,
    input  wire [1:0]  len,
    input  wire        rw,
    input  wire        addr_strobe_n,
    input  wire        data_strobe_n,
    input  wire [15:0] data_out,
    // Test control
    input  wire        is16,
    input  wire        quiet,
    input  wire [1:0]  dly,
    // Answer
    output wire [15:0] data_in,
    output reg         port_ack_lo,
    output reg         port_ack_hi
);
    reg [7:0] mem [0:255];
    reg [1:0] cnt;
    reg       tog;
    integer   i;
    wire [7:0]  a = addr[7:0];
    wire [7:0]  ae = {a[7:1], 1'b0};
    wire [15:0] rd16 = {mem[ae], mem[ae | 8'h01]};
    wire [15:0] rd8 = {mem[a], 8'hc3 ^ {8{tog}}};
    // Released lines show a changing pattern, never the last data
    assign data_in = (!data_strobe_n && rw) ? (is16 ? rd16 : rd8)
                   : 16'h5a3c ^ {16{tog}};
    initial begin
        for (i = 0; i < 256; i = i + 1)
            mem[i] = i[7:0] * 8'h1d + 8'h07;
        {port_ack_hi, port_ack_lo} = 2'b11;
        cnt = 2'h0;
        tog = 1'b0;
    end
    always @(posedge ref_clk) begin
        tog <= ~tog;
        if (addr_strobe_n) begin
            cnt <= 2'h0;
            {port_ack_hi, port_ack_lo} <= 2'b11;
        end else if (!data_strobe_n) begin
            if (cnt != dly)
                cnt <= cnt + 2'h1;
            else if (!quiet)
                {port_ack_hi, port_ack_lo} <= is16 ? 2'b01 : 2'b10;
            if (!rw && !is16)
                mem[a] <= data_out[15:8];
            else if (!rw && len != 2'b01) begin
                mem[ae] <= data_out[15:8];
                mem[ae | 8'h01] <= data_out[7:0];
            end else if (!rw)
                mem[a] <= a[0] ? data_out[7:0] : data_out[15:8];
        end
    end
endmodule

// [ext_bus_dynamic_sizing_bench.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checked = checked + 1; if ((g) !== (e)) begin \
    n_mismatch = n_mismatch + 1; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ext_bus_dynamic_sizing_bench;
    reg         ref_clk = 0, rst_n = 0, req_valid = 0, req_write = 0;
    reg         req_int_ack = 0, req_int_16 = 0, is16 = 0, pas = 1, mis;
    reg  [1:0]  req_size = 0, dly = 0;
    reg  [3:0]  req_wait = 0;
    reg  [23:0] req_addr = 0;
    reg  [31:0] req_wdata = 0, ev, r;
    reg  [7:0]  bm [0:255];
    wire        req_ready, done, misaligned, rw, as_n, ds_n, oe_n, lh, ll;
    wire        ack_lo, ack_hi;
    wire [31:0] rdata;
    wire [23:0] addr;
    wire [15:0] data_out, data_in;
    integer     n_mismatch = 0, checked = 0, ncyc = 0, t, nb;
    ext_bus_sizer u_ext_bus_sizer (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(1'b1), .req_valid(req_valid), .req_write(req_write),
        .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_int_ack(req_int_ack), .req_wait(req_wait),
        .req_int_16(req_int_16), .req_ready(req_ready), .done(done),
        .misaligned(misaligned), .rdata(rdata), .addr(addr),
        .xfer_len_hi(lh), .xfer_len_lo(ll), .rw(rw), .addr_strobe_n(as_n),
        .data_strobe_n(ds_n), .data_out(data_out), .data_oe_n(oe_n),
        .data_in(data_in), .port_ack_lo(ack_lo), .port_ack_hi(ack_hi));
    ext_slave_model u_ext_slave_model (.ref_clk(ref_clk), .addr(addr),
        .len({lh, ll}), .rw(rw), .addr_strobe_n(as_n), .data_strobe_n(ds_n),
        .data_out(data_out), .is16(is16), .quiet(req_int_ack), .dly(dly),
        .data_in(data_in), .port_ack_lo(ack_lo), .port_ack_hi(ack_hi));
    always #5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        if (pas && !as_n)
            ncyc = ncyc + 1;
        pas = as_n;
    end
    task end_sim;
        begin
            $display("checked %0d mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task run_op(input wr, input [1:0] sz, input [7:0] a, input [31:0] wd);
        integer w, k, got;
        begin
            ncyc = 0;
            got = 0;
            @(posedge ref_clk);
            req_write <= wr;
            req_size <= sz;
            req_addr <= {r[31:16], a};
            req_wdata <= wd;
            req_valid <= 1'b1;
            for (w = 0; w < 300 && got == 0; w = w + 1) begin
                @(negedge ref_clk);
                if (done === 1'b1) begin
                    got = 1;
                    mis = misaligned;
                end
            end
            if (got == 0) begin
                n_mismatch = n_mismatch + 1;
                end_sim;
            end
            // Drop the request on the edge that ends the done cycle
            @(posedge ref_clk);
            req_valid <= 1'b0;
            nb = (sz == 2'b00) ? 1 : (sz == 2'b01) ? 2 : 4;
            `CHK(mis, (sz != 2'b00) && a[0])
            if (sz != 2'b00 && a[0])
                nb = 0;
            `CHK(ncyc, is16 ? (nb + 1) / 2 : nb)
            ev = 32'h0;
            for (k = 0; k < nb; k = k + 1) begin
                if (wr)
                    bm[(a + k) % 256] = wd[8 * (nb - 1 - k) +: 8];
                ev = {ev[23:0], bm[(a + k) % 256]};
            end
            if (!wr && nb != 0)
                `CHK(rdata, ev)
        end
    endtask
    initial begin
        for (t = 0; t < 256; t = t + 1)
            bm[t] = t[7:0] * 8'h1d + 8'h07;
        r = $urandom(36);
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (t = 0; t < 60; t = t + 1) begin
            @(posedge ref_clk);
            r = $urandom;
            is16 <= r[0];
            req_int_16 <= r[0];
            req_int_ack <= r[1];
            req_wait <= {2'b00, r[5:4]};
            dly <= r[7:6];
            run_op(r[8], (r[10:9] == 2'b11) ? 2'b10 : r[10:9], r[23:16],
                   $urandom);
            if (r[8])
                run_op(1'b0, req_size, r[23:16], 32'h0);
            $display("test %0d done", t);
        end
        end_sim;
    end
endmodule
bind ext_bus_sizer ext_bus_sizer_properties u_props (.ref_clk(ref_clk),
    .rst_n(rst_n), .req_size(req_size), .req_wdata(req_wdata),
    .done(done), .misaligned(misaligned), .addr(addr),
    .xfer_len_hi(xfer_len_hi), .xfer_len_lo(xfer_len_lo), .rw(rw),
    .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n),
    .data_out(data_out), .data_oe_n(data_oe_n),
    .port_ack_lo(port_ack_lo), .port_ack_hi(port_ack_hi));
